// ### common/param_store_pkg.sv
/*
 * Parameter store constants: indices, resets, ranges, commands, timing.
 * Assumes a 200 MHz system clock.
 */
package param_store_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int SAVE_LIMIT_MS = 100;

    localparam logic [15:0] IDX_END_HOLD = 16'h2043;
    localparam logic [15:0] IDX_WAIT_BEFORE = 16'h2044;
    localparam logic [15:0] IDX_WAIT_AFTER = 16'h2045;
    localparam logic [15:0] IDX_FREE_STEPS = 16'h2048;
    localparam logic [15:0] IDX_KEY_ACT = 16'h204C;
    localparam logic [15:0] IDX_MODEL = 16'h204D;
    localparam logic [15:0] IDX_VERSION = 16'h204E;
    localparam logic [15:0] IDX_COMMAND = 16'h204F;

    localparam logic [15:0] RST_END_HOLD = 16'h00C8;
    localparam logic [15:0] RST_WAIT_BEFORE = 16'h0096;
    localparam logic [15:0] RST_WAIT_AFTER = 16'h03E8;
    localparam logic [15:0] RST_FREE_STEPS = 16'h0001;
    localparam logic [15:0] RST_KEY_ACT = 16'h0000;

    localparam logic [15:0] MAX_END_HOLD = 16'h03E8;
    localparam logic [15:0] MAX_WAIT_BEFORE = 16'h07D0;
    localparam logic [15:0] MAX_WAIT_AFTER = 16'h0BB8;
    localparam logic [15:0] MIN_FREE_STEPS = 16'h0001;
    localparam logic [15:0] MAX_FREE_STEPS = 16'h0032;
    localparam logic [15:0] MAX_KEY_ACT = 16'h0001;

    localparam logic [15:0] CMD_SAVE = 16'h0001;
    localparam logic [15:0] CMD_DEFAULTS_KEEP = 16'hFFFF;
    localparam logic [15:0] CMD_DEFAULTS_ALL = 16'hFFFE;

    localparam logic [7:0] FACTORY_NODE = 8'h01;
    localparam logic [2:0] FACTORY_BAUD = 3'h3;

    localparam int CW_BUS_POS_BIT = 4;
    localparam int CW_JOG_BIT = 5;
    localparam int CW_KEY_LO_BIT = 8;
    localparam int CW_KEY_HI_BIT = 9;

    localparam logic [15:0] STATUS_OK = 16'h0000;
    localparam logic [15:0] STATUS_BUSY = 16'h0001;
    localparam logic [15:0] STATUS_FAIL = 16'h0002;
    localparam logic [15:0] STATUS_BAD_MEM = 16'h0003;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_PRE_BRAKE = 3'b001,
        PH_MOVING = 3'b010,
        PH_END_HOLD = 3'b011,
        PH_POST_BRAKE = 3'b100
    } run_phase_type;
endpackage

// ### rtl/drive_brake_key_param_store.sv
/*
 * Drive parameter objects: run timing, step count, key enable and the
 * defaults/save command with memory status.
 * Assumes decoded object accesses arrive one at a time and a memory
 * engine reports save completion.
 */
`timescale 1ns/10ps
// What this block does
// RULE1 - after each run, hold end-of-run torque for set ms, default 200
// RULE2 - before motion, release brake and wait programmed ms, default 150
// RULE3 - after run, keep brake released programmed ms, default 1000
// RULE4 - hold 16-bit braking-free step count parameter
// RULE5 - no bus: keys on if setting 1, or setting 0 with address 0/1
// RULE6 - bus, setting 0: keys on when jog bit 5 set, bit 4 clear
// RULE7 - bus, setting 1: keys also on in pre-operational state
// RULE8 - while keys enabled, control word bits 8 and 9 are ignored
// RULE9 - command -1 restores defaults, keeps address and baud, references
// RULE10 - command -2 restores all, address 1, 500 kBaud, then references
// RULE11 - new address or baud applies only after device or comm reset
// RULE12 - command 1 starts saving all parameters to nonvolatile memory
// RULE13 - status read after boot: 0 if memory valid, else nonzero
// RULE14 - status read after save: 0 done ok, nonzero busy or failed
// RULE15 - save finishes within 100 ms; master polls for zero
// RULE16 - model code and version are read-only; writes do nothing
// RULE17 - out-of-range values or unknown commands refused, value kept
module drive_brake_key_param_store #(
    parameter logic [15:0] MODEL_CODE = 16'h1234, // arbitrary value
    parameter logic [15:0] FW_VERSION = 16'h0100, // arbitrary value
    parameter int MS_CYCLES = param_store_pkg::CYCLES_PER_MS,
    parameter int SAVE_LIMIT_CYCLES =
        param_store_pkg::SAVE_LIMIT_MS * param_store_pkg::CYCLES_PER_MS
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic acc_valid_in,
    input wire logic acc_write_in,
    input wire logic [15:0] acc_index_in,
    input wire logic [15:0] acc_wdata_in,
    output logic acc_done_out,
    output logic acc_error_out,
    output logic [15:0] acc_rdata_out,
    input wire logic comm_reset_in,
    input wire logic [7:0] pending_node_in,
    input wire logic [2:0] pending_baud_in,
    output logic [7:0] active_node_out,
    output logic [2:0] active_baud_out,
    output logic set_factory_comm_out,
    output logic restore_defaults_out,
    output logic reference_run_out,
    input wire logic bus_connected_in,
    input wire logic preop_in,
    input wire logic [7:0] addr_switch_in,
    input wire logic [15:0] control_word_in,
    output logic keys_enabled_out,
    output logic [15:0] eff_control_word_out,
    input wire logic run_request_in,
    input wire logic motion_done_in,
    output logic brake_release_out,
    output logic motor_enable_out,
    output logic end_hold_torque_out,
    output logic [15:0] free_step_count_out,
    input wire logic mem_valid_in,
    input wire logic save_done_in,
    input wire logic save_ok_in,
    output logic save_start_out
);
    import param_store_pkg::*;

    localparam int CNT_W = 32;

    // pins from outside: two-stage synchronisers
    logic [7:0] sw_s1, sw_s2;
    logic bus_s1, bus_s2;

    logic [15:0] end_hold_torque_duration;
    logic [15:0] brake_wait_before_run;
    logic [15:0] brake_wait_after_run;
    logic [15:0] brake_free_step_count;
    logic [15:0] external_key_activation;
    logic [15:0] save_status;
    logic saving;
    logic [CNT_W-1:0] save_cnt;

    run_phase_type phase, next_phase;
    logic [CNT_W-1:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] next_ms;
    logic ms_tick;

    function automatic logic in_range(input logic [15:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // access decode
    wire wr = acc_valid_in && acc_write_in;
    wire hit_end = acc_index_in == IDX_END_HOLD;
    wire hit_before = acc_index_in == IDX_WAIT_BEFORE;
    wire hit_after = acc_index_in == IDX_WAIT_AFTER;
    wire hit_steps = acc_index_in == IDX_FREE_STEPS;
    wire hit_key = acc_index_in == IDX_KEY_ACT;
    wire hit_model = acc_index_in == IDX_MODEL;
    wire hit_ver = acc_index_in == IDX_VERSION;
    wire hit_cmd = acc_index_in == IDX_COMMAND;
    wire hit_any = hit_end | hit_before | hit_after | hit_steps | hit_key |
                   hit_model | hit_ver | hit_cmd;
    wire cmd_save = acc_wdata_in == CMD_SAVE;
    wire cmd_keep = acc_wdata_in == CMD_DEFAULTS_KEEP;
    wire cmd_all = acc_wdata_in == CMD_DEFAULTS_ALL;
    wire w_end_ok = wr && hit_end &&
        in_range(acc_wdata_in, 16'h0000, MAX_END_HOLD); // RULE17
    wire w_before_ok = wr && hit_before &&
        in_range(acc_wdata_in, 16'h0000, MAX_WAIT_BEFORE); // RULE17
    wire w_after_ok = wr && hit_after &&
        in_range(acc_wdata_in, 16'h0000, MAX_WAIT_AFTER); // RULE17
    wire w_steps_ok = wr && hit_steps &&
        in_range(acc_wdata_in, MIN_FREE_STEPS, MAX_FREE_STEPS); // RULE17
    wire w_key_ok = wr && hit_key &&
        in_range(acc_wdata_in, 16'h0000, MAX_KEY_ACT); // RULE17
    // a save while one is running is refused rather than restarted
    wire w_save = wr && hit_cmd && cmd_save && !saving; // RULE12
    wire w_def = wr && hit_cmd && (cmd_keep || cmd_all); // RULE9 RULE10
    wire w_ok = w_end_ok | w_before_ok | w_after_ok | w_steps_ok |
                w_key_ok | w_save | w_def;
    // read-only objects refuse writes, storage untouched
    wire acc_err = acc_valid_in &&
        (!hit_any || (acc_write_in && !w_ok)); // RULE16

    logic [15:0] rd_mux;
    always_comb begin
        unique case (1'b1)
            hit_end: rd_mux = end_hold_torque_duration;
            hit_before: rd_mux = brake_wait_before_run;
            hit_after: rd_mux = brake_wait_after_run;
            hit_steps: rd_mux = brake_free_step_count;
            hit_key: rd_mux = external_key_activation;
            hit_model: rd_mux = MODEL_CODE; // RULE16
            hit_ver: rd_mux = FW_VERSION; // RULE16
            hit_cmd: rd_mux = save_status; // RULE13 RULE14
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in) begin
        sw_s1 <= addr_switch_in;
        sw_s2 <= sw_s1;
        bus_s1 <= bus_connected_in;
        bus_s2 <= bus_s1;
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            acc_done_out <= 1'b0;
            acc_error_out <= 1'b0;
            acc_rdata_out <= 16'h0000;
        end else begin
            acc_done_out <= acc_valid_in;
            acc_error_out <= acc_err;
            acc_rdata_out <= (acc_valid_in && !acc_write_in) ?
                rd_mux : 16'h0000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in || w_def) begin
            end_hold_torque_duration <= RST_END_HOLD; // RULE1
            brake_wait_before_run <= RST_WAIT_BEFORE; // RULE2
            brake_wait_after_run <= RST_WAIT_AFTER; // RULE3
            brake_free_step_count <= RST_FREE_STEPS; // RULE4
            external_key_activation <= RST_KEY_ACT;
        end else begin
            if (w_end_ok) end_hold_torque_duration <= acc_wdata_in;
            if (w_before_ok) brake_wait_before_run <= acc_wdata_in;
            if (w_after_ok) brake_wait_after_run <= acc_wdata_in;
            if (w_steps_ok) brake_free_step_count <= acc_wdata_in; // RULE4
            if (w_key_ok) external_key_activation <= acc_wdata_in;
        end
    end

    // defaults command: one-cycle pulses to the motion and comm layers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            restore_defaults_out <= 1'b0;
            set_factory_comm_out <= 1'b0;
            reference_run_out <= 1'b0;
        end else begin
            restore_defaults_out <= w_def; // RULE9
            set_factory_comm_out <= w_def && cmd_all; // RULE10
            reference_run_out <= w_def; // RULE9 RULE10
        end
    end

    // pending comm values only go live here
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || comm_reset_in) begin
            active_node_out <= pending_node_in; // RULE11
            active_baud_out <= pending_baud_in; // RULE11
        end
    end

    // save engine status; a watchdog marks a stuck save as failed
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            saving <= 1'b0;
            save_cnt <= '0;
            save_start_out <= 1'b0;
            save_status <= STATUS_BAD_MEM;
        end else begin
            save_start_out <= w_save; // RULE12
            if (w_save) begin
                saving <= 1'b1;
                save_cnt <= '0;
                save_status <= STATUS_BUSY; // RULE14
            end else if (saving) begin
                save_cnt <= save_cnt + 1'b1;
                if (save_done_in) begin
                    saving <= 1'b0;
                    save_status <= save_ok_in ? STATUS_OK :
                        STATUS_FAIL; // RULE14
                end else if (save_cnt >= CNT_W'(SAVE_LIMIT_CYCLES - 1)) begin
                    saving <= 1'b0;
                    save_status <= STATUS_FAIL; // RULE15
                end
            end else if (save_status == STATUS_BAD_MEM && mem_valid_in) begin
                save_status <= STATUS_OK; // RULE13
            end
        end
    end

    // key enable and control word masking
    wire key_set = external_key_activation[0];
    wire addr_low = sw_s2 <= 8'h01;
    wire cw_jog = control_word_in[CW_JOG_BIT] &&
                  !control_word_in[CW_BUS_POS_BIT];
    wire keys_on = !bus_s2 ? (key_set || addr_low) // RULE5
                 : (cw_jog || (key_set && preop_in)); // RULE6 RULE7
    logic [15:0] cw_masked;
    always_comb begin
        cw_masked = control_word_in;
        if (keys_on) begin
            cw_masked[CW_KEY_LO_BIT] = 1'b0; // RULE8
            cw_masked[CW_KEY_HI_BIT] = 1'b0; // RULE8
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            keys_enabled_out <= 1'b0;
            eff_control_word_out <= 16'h0000;
            free_step_count_out <= RST_FREE_STEPS;
        end else begin
            keys_enabled_out <= keys_on;
            eff_control_word_out <= cw_masked;
            free_step_count_out <= brake_free_step_count; // RULE4
        end
    end

    // millisecond timer for the run sequence
    assign ms_tick = tick_cnt == CNT_W'(MS_CYCLES - 1);
    wire phase_change = next_phase != phase;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || phase_change || ms_tick)
            tick_cnt <= '0;
        else
            tick_cnt <= tick_cnt + 1'b1;
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || phase_change)
            ms_cnt <= 16'h0000;
        else if (ms_tick)
            ms_cnt <= ms_cnt + 16'h0001;
    end
    assign next_ms = ms_cnt + 16'h0001;
    wire ms_elapsed_before = ms_tick && next_ms >= brake_wait_before_run;
    wire ms_elapsed_hold = ms_tick && next_ms >= end_hold_torque_duration;
    wire ms_elapsed_after = ms_tick && next_ms >= brake_wait_after_run;

    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_IDLE: if (run_request_in) next_phase = PH_PRE_BRAKE;
            PH_PRE_BRAKE:
                if (brake_wait_before_run == 16'h0000 || ms_elapsed_before)
                    next_phase = PH_MOVING; // RULE2
            PH_MOVING: if (motion_done_in) next_phase = PH_END_HOLD;
            PH_END_HOLD:
                if (end_hold_torque_duration == 16'h0000 || ms_elapsed_hold)
                    next_phase = PH_POST_BRAKE; // RULE1
            PH_POST_BRAKE:
                if (brake_wait_after_run == 16'h0000 || ms_elapsed_after)
                    next_phase = PH_IDLE; // RULE3
            default: next_phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            phase <= PH_IDLE;
            brake_release_out <= 1'b0;
            motor_enable_out <= 1'b0;
            end_hold_torque_out <= 1'b0;
        end else begin
            phase <= next_phase;
            brake_release_out <= next_phase != PH_IDLE; // RULE2 RULE3
            motor_enable_out <= next_phase == PH_MOVING; // RULE2
            end_hold_torque_out <= next_phase == PH_END_HOLD; // RULE1
        end
    end

    AST_MOTOR_NOT_BEFORE_WAIT: assert property (@(posedge clk_in) // RULE2
        disable iff (!reset_n_in)
        $rose(brake_release_out) && brake_wait_before_run != 16'h0000
        |-> !motor_enable_out [*2])
        else $error("motor moved before brake wait");
    AST_HOLD_AFTER_RUN: assert property (@(posedge clk_in) // RULE1
        disable iff (!reset_n_in)
        phase == PH_MOVING && motion_done_in |=> end_hold_torque_out ||
        end_hold_torque_duration == 16'h0000)
        else $error("end hold torque not applied");
    AST_BRAKE_HELD_AFTER: assert property (@(posedge clk_in) // RULE3
        disable iff (!reset_n_in)
        $fell(end_hold_torque_out) && brake_wait_after_run != 16'h0000
        |-> brake_release_out)
        else $error("brake engaged too early");
    AST_CW_MASK: assert property (@(posedge clk_in) // RULE8
        disable iff (!reset_n_in)
        keys_enabled_out |-> eff_control_word_out[CW_KEY_HI_BIT:
        CW_KEY_LO_BIT] == 2'b00)
        else $error("control bits 8/9 not masked");
    AST_KEYS_JOG: assert property (@(posedge clk_in) // RULE6
        disable iff (!reset_n_in)
        bus_s2 && control_word_in[CW_JOG_BIT] &&
        !control_word_in[CW_BUS_POS_BIT] |=> keys_enabled_out)
        else $error("jog keys not enabled");
    AST_KEYS_NOBUS: assert property (@(posedge clk_in) // RULE5
        disable iff (!reset_n_in)
        !bus_s2 && !key_set && sw_s2 > 8'h01 |=> !keys_enabled_out)
        else $error("keys enabled at wrong address");
    AST_KEYS_PREOP: assert property (@(posedge clk_in) // RULE7
        disable iff (!reset_n_in)
        bus_s2 && key_set && preop_in |=> keys_enabled_out)
        else $error("keys not enabled in preop");
    AST_SAVE_BUSY: assert property (@(posedge clk_in) // RULE14
        disable iff (!reset_n_in)
        w_save |=> save_start_out && save_status != STATUS_OK)
        else $error("save status not busy");
    AST_SAVE_BOUND: assert property (@(posedge clk_in) // RULE15
        disable iff (!reset_n_in)
        saving |-> save_cnt < CNT_W'(SAVE_LIMIT_CYCLES))
        else $error("save exceeded limit");
    AST_RO_REFUSE: assert property (@(posedge clk_in) // RULE16
        disable iff (!reset_n_in)
        acc_valid_in && acc_write_in && (hit_model || hit_ver)
        |=> acc_error_out && acc_done_out)
        else $error("read-only write accepted");
    AST_RANGE_KEEP: assert property (@(posedge clk_in) // RULE17
        disable iff (!reset_n_in)
        wr && hit_end && acc_wdata_in > MAX_END_HOLD
        |=> $stable(end_hold_torque_duration) && acc_error_out)
        else $error("out-of-range write stored");
    AST_DEF_ALL: assert property (@(posedge clk_in) // RULE10
        disable iff (!reset_n_in)
        wr && hit_cmd && cmd_all |=> set_factory_comm_out &&
        reference_run_out && brake_wait_after_run == RST_WAIT_AFTER)
        else $error("factory restore incomplete");
endmodule

// ### tb/drive_brake_key_param_store_bench.sv
/* Self-checking bench for the parameter store: the master model makes
   accesses, the bench plays memory, network and motion control.
   Assumes MS cycles per millisecond. */
`timescale 1ns/10ps
module drive_brake_key_param_store_bench;
    import param_store_pkg::*;
    localparam int MS = 10;
    localparam logic [15:0] MODEL = 16'h5A5A; // arbitrary value
    localparam logic [15:0] VER = 16'h0203; // arbitrary value
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic av, aw, ad, ae, crst, fac, rest, refr, bus, pre, keys, ok, a, e;
    logic [15:0] ai, adat, ard, cw, ecw, steps, v;
    logic [7:0] pnode, anode, sw;
    logic [2:0] pbaud, abaud;
    logic runq, mdone, brake, motor, torque, memv, sdone, sok, sstart;
    int failures;
    int samples_checked;
    int cycles;
    int n_save, n_fac, n_rest, n_ref;
    int n, s0, r0, f0, q0;
    logic [15:0] idx [5] = '{IDX_END_HOLD, IDX_WAIT_BEFORE, IDX_WAIT_AFTER,
                             IDX_FREE_STEPS, IDX_KEY_ACT};
    logic [15:0] lo [5] = '{16'h0000, 16'h0000, 16'h0000, MIN_FREE_STEPS,
                            16'h0000};
    logic [15:0] hi [5] = '{MAX_END_HOLD, MAX_WAIT_BEFORE, MAX_WAIT_AFTER,
                            MAX_FREE_STEPS, MAX_KEY_ACT};
    logic [15:0] dflt [5] = '{RST_END_HOLD, RST_WAIT_BEFORE, RST_WAIT_AFTER,
                              RST_FREE_STEPS, RST_KEY_ACT};

    drive_brake_key_param_store #(.MODEL_CODE(MODEL), .FW_VERSION(VER),
        .MS_CYCLES(MS), .SAVE_LIMIT_CYCLES(1000)) uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .acc_valid_in(av),
        .acc_write_in(aw), .acc_index_in(ai), .acc_wdata_in(adat),
        .acc_done_out(ad), .acc_error_out(ae), .acc_rdata_out(ard),
        .comm_reset_in(crst), .pending_node_in(pnode),
        .pending_baud_in(pbaud), .active_node_out(anode),
        .active_baud_out(abaud), .set_factory_comm_out(fac),
        .restore_defaults_out(rest), .reference_run_out(refr),
        .bus_connected_in(bus), .preop_in(pre), .addr_switch_in(sw),
        .control_word_in(cw), .keys_enabled_out(keys),
        .eff_control_word_out(ecw), .run_request_in(runq),
        .motion_done_in(mdone), .brake_release_out(brake),
        .motor_enable_out(motor), .end_hold_torque_out(torque),
        .free_step_count_out(steps), .mem_valid_in(memv),
        .save_done_in(sdone), .save_ok_in(sok), .save_start_out(sstart));
    sdo_master_model master (.clk_in(clk_in), .acc_done_in(ad),
        .acc_error_in(ae), .acc_rdata_in(ard), .acc_valid_out(av),
        .acc_write_out(aw), .acc_index_out(ai), .acc_wdata_out(adat));

    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        n_save += int'(sstart === 1'b1);
        n_fac += int'(fac === 1'b1);
        n_rest += int'(rest === 1'b1);
        n_ref += int'(refr === 1'b1);
        if (cycles == 10000) begin
            failures++;
            report_and_stop();
        end
    end

    function automatic logic keys_exp(logic bc, logic act, logic pr,
                                      logic [7:0] s, logic [15:0] c);
        if (!bc)
            return act || s <= 8'h01;
        return (c[CW_JOG_BIT] && !c[CW_BUS_POS_BIT]) || (act && pr);
    endfunction
    task automatic chk16(input logic [15:0] g, input logic [15:0] x,
                         input string m);
        samples_checked++;
        if (g !== x) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x, input string m);
        chk16(16'(g), 16'(x), m);
    endtask
    task automatic wr(input logic [15:0] i, input logic [15:0] d,
                      input logic er);
        master.access(1'b1, i, d, ok);
        chk1(ok, 1'b1, "write done");
        chk1(master.err, er, "write error flag");
    endtask
    task automatic rd(input logic [15:0] i, input logic [15:0] x);
        master.access(1'b0, i, 16'h0000, ok);
        chk1(ok && !master.err, 1'b1, "read answer");
        chk16(master.rd, x, "read data");
    endtask
    // falling edges while s stays at lvl, capped against a hang
    task automatic span(ref logic s, input logic lvl, output int k);
        k = 0;
        while (s === lvl && k < 1000) begin
            @(negedge clk_in);
            k++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        pnode = 8'h05;
        pbaud = 3'h2;
        {crst, bus, pre, runq, mdone, memv, sdone, sok, sw, cw} = '0;
        void'($urandom(67));
        repeat (4) @(negedge clk_in);
        reset_n_in = 1'b1;
        chk16({anode, 5'h00, abaud}, 16'h0502, "active comm");
        master.access(1'b0, IDX_COMMAND, 16'h0000, ok);
        chk1(master.rd != 16'h0000, 1'b1, "boot status");
        memv = 1'b1;
        repeat (3) @(negedge clk_in);
        rd(IDX_COMMAND, 16'h0000);
        for (int i = 0; i < 5; i++)
            rd(idx[i], dflt[i]);
        rd(IDX_MODEL, MODEL);
        rd(IDX_VERSION, VER);
        wr(IDX_MODEL, 16'h0000, 1'b1);
        rd(IDX_MODEL, MODEL);
        master.access(1'b0, 16'h2046, 16'h0000, ok);
        chk1(master.err, 1'b1, "unknown index");
        $display("test reset values finished");
        for (int i = 0; i < 5; i++) begin
            v = lo[i] + 16'($urandom % (32'(hi[i] - lo[i]) + 1));
            wr(idx[i], hi[i], 1'b0);
            rd(idx[i], hi[i]);
            wr(idx[i], v, 1'b0);
            wr(idx[i], hi[i] + 16'h0001 + 16'($urandom % 64), 1'b1);
            if (lo[i] != 16'h0000)
                wr(idx[i], lo[i] - 16'h0001, 1'b1);
            rd(idx[i], v);
        end
        wr(IDX_COMMAND, 16'h0002, 1'b1);
        $display("test ranges finished");
        for (int c = 0; c < 2; c++) begin
            wr(IDX_END_HOLD, 16'h0007, 1'b0);
            r0 = n_rest;
            f0 = n_fac;
            q0 = n_ref;
            wr(IDX_COMMAND, c ? CMD_DEFAULTS_ALL : CMD_DEFAULTS_KEEP,
               1'b0);
            repeat (3) @(negedge clk_in);
            chk16(16'(n_rest - r0), 16'h0001, "restore");
            chk16(16'(n_ref - q0), 16'h0001, "reference");
            chk16(16'(n_fac - f0), 16'(c), "factory comm");
            for (int i = 0; i < 5; i++)
                rd(idx[i], dflt[i]);
            chk16({anode, 5'h00, abaud}, 16'h0502, "comm kept");
        end
        pnode = 8'h2A;
        pbaud = 3'h4;
        repeat (3) @(negedge clk_in);
        chk16({anode, 5'h00, abaud}, 16'h0502, "comm pending");
        crst = 1'b1;
        @(negedge clk_in);
        crst = 1'b0;
        repeat (2) @(negedge clk_in);
        chk16({anode, 5'h00, abaud}, 16'h2A04, "comm applied");
        $display("test defaults finished");
        for (int i = 0; i < 24; i++) begin
            a = 1'($urandom % 2);
            wr(IDX_KEY_ACT, {15'h0000, a}, 1'b0);
            bus = 1'($urandom % 2);
            pre = 1'($urandom % 2);
            sw = 8'(i % 4);
            cw = 16'($urandom);
            // every third pass sets jog bit 5 and clears bit 4
            if (i % 3 == 0)
                cw = (cw | 16'h0020) & 16'hFFEF;
            repeat (6) @(negedge clk_in);
            e = keys_exp(bus, a, pre, sw, cw);
            chk1(keys, e, "keys enabled");
            chk16(ecw, e ? cw & 16'hFCFF : cw, "control word");
        end
        $display("test keys finished");
        wr(IDX_WAIT_BEFORE, 16'h0002, 1'b0);
        wr(IDX_END_HOLD, 16'h0003, 1'b0);
        wr(IDX_WAIT_AFTER, 16'h0001, 1'b0);
        wr(IDX_FREE_STEPS, 16'h0032, 1'b0);
        @(negedge clk_in);
        chk16(steps, 16'h0032, "step count");
        runq = 1'b1;
        @(negedge clk_in);
        runq = 1'b0;
        chk1(brake, 1'b1, "brake released");
        span(motor, 1'b0, n);
        chk1(n >= 2 * MS - 2 && n <= 2 * MS + 1, 1'b1, "brake wait");
        mdone = 1'b1;
        @(negedge clk_in);
        mdone = 1'b0;
        span(torque, 1'b0, n);
        chk1(n <= 2, 1'b1, "hold start");
        span(torque, 1'b1, n);
        chk1(n >= 3 * MS - 2 && n <= 3 * MS + 1, 1'b1, "hold time");
        span(brake, 1'b1, n);
        chk1(n >= MS - 2 && n <= MS + 1, 1'b1, "brake after run");
        $display("test run finished");
        for (int k = 0; k < 3; k++) begin
            s0 = n_save;
            wr(IDX_COMMAND, CMD_SAVE, 1'b0);
            if (k == 0)
                wr(IDX_COMMAND, CMD_SAVE, 1'b1);
            repeat (2) @(negedge clk_in);
            chk16(16'(n_save - s0), 16'h0001, "save start");
            master.access(1'b0, IDX_COMMAND, 16'h0000, ok);
            chk1(master.rd != 16'h0000, 1'b1, "save busy");
            repeat ($urandom % 8) @(negedge clk_in);
            sok = (k == 0);
            sdone = (k < 2);
            @(negedge clk_in);
            sdone = 1'b0;
            // no memory answer: the watchdog must expire
            if (k == 2)
                repeat (1004) @(negedge clk_in);
            master.poll_zero(3, ok);
            chk1(ok, 1'(k == 0), "save result");
        end
        $display("test save finished");
        report_and_stop();
    end
endmodule

// ### tb/sdo_master_model.sv
/* Bus master model: one 16-bit object access at a time, answer kept.
   Assumes the answer comes the cycle after the request. */
`timescale 1ns/10ps
module sdo_master_model
    import param_store_pkg::*;
(
    input wire logic clk_in,
    input wire logic acc_done_in,
    input wire logic acc_error_in,
    input wire logic [15:0] acc_rdata_in,
    output logic acc_valid_out,
    output logic acc_write_out,
    output logic [15:0] acc_index_out,
    output logic [15:0] acc_wdata_out
);
    logic err;
    logic [15:0] rd;
    initial begin
        acc_valid_out = 1'b0;
        acc_write_out = 1'b0;
        acc_index_out = 16'h0000;
        acc_wdata_out = 16'h0000;
    end
    task automatic access(input logic wr, input logic [15:0] idx,
                          input logic [15:0] d, output logic ok);
        @(negedge clk_in);
        acc_valid_out = 1'b1;
        acc_write_out = wr;
        acc_index_out = idx;
        acc_wdata_out = d;
        @(posedge clk_in);
        @(negedge clk_in);
        ok = acc_done_in === 1'b1;
        err = acc_error_in;
        rd = acc_rdata_in;
        acc_valid_out = 1'b0;
        // released data shows the inverse
        acc_wdata_out = ~d;
    endtask
    // trust stored values only once the status reads zero
    task automatic poll_zero(input int tries, output logic ok);
        logic got;
        ok = 1'b0;
        for (int i = 0; i < tries && !ok; i++) begin
            access(1'b0, IDX_COMMAND, 16'h0000, got);
            ok = got && rd === 16'h0000;
        end
    endtask
endmodule
